/* adc_cfg_map.svh */
// Register addresses, field positions, codes and timing figures of the configuration block.
`ifndef ADC_CFG_MAP_SVH
`define ADC_CFG_MAP_SVH
`define ADDR_RESET 7'h00
`define ADDR_POWER 7'h01
`define ADDR_CLOCK 7'h02
`define ADDR_DRIVE 7'h03
`define ADDR_FORMAT 7'h04
`define REG_CLEAR 8'h00
`define RST_BIT 7
`define PD_SLEEP_BIT 3
`define PD_NAP_BIT 2
`define PD_MASK 8'h0C
`define CLK_DCS_BIT 0
`define CLK_INV_BIT 3
`define CLK_MASK 8'h09
`define DRV_DISABLE_BIT 3
`define DRV_CODE_HI 2
`define DRV_MASK 8'h0F
`define FMT_TWOS_BIT 0
`define FMT_RAND_BIT 1
`define FMT_ABP_BIT 2
`define FMT_PAT_LO 3
`define FMT_PAT_HI 4
`define FMT_TEST_BIT 5
`define FMT_MASK 8'h3F
`define DRIVE_3P5MA 3'h0
`define DRIVE_1P75MA 3'h1
`define OB_ZERO 12'h800
`define CODE_MAX 12'hFFF
`define CODE_MIN 12'h000
`define ODD_MASK 12'hAAA
`define PAT_SEL_ONES 2'h0
`define PAT_SEL_ZEROS 2'h1
`define PAT_SEL_ALT 2'h2
`define PAT_ONES 13'h1FFF
`define PAT_ZEROS 13'h0000
`define PAT_CHECK_A 13'h1555
`define PAT_CHECK_B 13'h0AAA
`define ADDR_LAST 5'h07
`define ADDR_END 5'h08
`define DATA_LAST 5'h0F
`define FRAME_BITS 5'h10
`define SLEEP_WAKE_NS 32'h0001_86A0
`define CLOCK_NS 32'h0000_0014
`define SLEEP_WAKE_SAMPLES 16'h09C4
`define NAP_WAKE_SAMPLES 16'h0064
`endif

/* adc_cfg_pkg.sv */
// Types shared by the configuration port and the output formatter.
`default_nettype none
package adc_cfg_pkg;
    typedef struct packed {
        logic range_flag;
        logic [11:0] data;
    } sample_t;
    typedef struct packed {
        logic test_pattern_enable;
        logic [1:0] pattern;
        logic abp;
        logic randomize;
        logic twos;
    } fmt_cfg_t;
    typedef enum logic [2:0] {
        PWR_RUN = 3'b000,
        PWR_SLEEP = 3'b001,
        PWR_NAP = 3'b010,
        PWR_WAKE_TIME = 3'b011,
        PWR_WAKE_SAMPLES = 3'b100
    } power_state_t;
endpackage : adc_cfg_pkg
`default_nettype wire

/* sample_formatter.sv */
// Output word formatter: clamp, number format, randomizer, alternate polarity, test patterns.
`timescale 1ns/1ps
`default_nettype none
`include "adc_cfg_map.svh"
module sample_formatter (
    input wire logic i_clock,
    input wire logic i_arst_n,
    input wire logic i_strobe,
    input wire logic [11:0] i_raw_code,
    input wire logic i_over,
    input wire logic i_under,
    input wire adc_cfg_pkg::fmt_cfg_t i_cfg,
    output logic o_strobe,
    output adc_cfg_pkg::sample_t o_sample
);
    import adc_cfg_pkg::*;
    sample_t word_reg, word_next;
    logic strobe_reg, strobe_next, phase_reg, phase_next;
    logic [11:0] code;
    always_comb begin
        code = i_raw_code;
        word_next = word_reg;
        phase_next = phase_reg;
        strobe_next = i_strobe;
        if (i_strobe) begin
            if (i_over) begin
                code = `CODE_MAX;
            end else if (i_under) begin
                code = `CODE_MIN;
            end
            if (i_cfg.twos) begin
                code = code ^ `OB_ZERO;
            end
            if (i_cfg.randomize) begin
                code = code ^ {{11{code[0]}}, 1'b0};
            end
            if (i_cfg.abp) begin
                code = code ^ `ODD_MASK;
            end
            word_next = {i_over | i_under, code};
            phase_next = 1'b0;
            if (i_cfg.test_pattern_enable) begin
                phase_next = ~phase_reg;
                case (i_cfg.pattern)
                    `PAT_SEL_ONES: word_next = `PAT_ONES;
                    `PAT_SEL_ZEROS: word_next = `PAT_ZEROS;
                    `PAT_SEL_ALT: word_next = phase_reg ? `PAT_ZEROS : `PAT_ONES;
                    default: word_next = phase_reg ? `PAT_CHECK_B : `PAT_CHECK_A;
                endcase
            end
        end
    end
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            word_reg <= '0;
            strobe_reg <= 1'b0;
            phase_reg <= 1'b0;
        end else begin
            word_reg <= word_next;
            strobe_reg <= strobe_next;
            phase_reg <= phase_next;
        end
    end
    assign o_strobe = strobe_reg;
    assign o_sample = word_reg;
    chk_twos_zero_code: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        i_strobe && !i_cfg.test_pattern_enable && i_cfg.twos && !i_cfg.randomize
        && !i_cfg.abp && !i_over && !i_under && i_raw_code == `OB_ZERO
        |=> o_strobe && o_sample.data == `CODE_MIN && !o_sample.range_flag)
        else $error("Zero input did not map to two's complement zero.");
    chk_range_aligned: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        i_strobe && !i_cfg.test_pattern_enable && i_over && !i_cfg.twos && !i_cfg.randomize
        && !i_cfg.abp |=> o_strobe && o_sample.range_flag && o_sample.data == `CODE_MAX)
        else $error("Overrange sample lost its flag or clamp.");
    chk_pattern_override: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        i_strobe && i_cfg.test_pattern_enable && i_cfg.pattern == `PAT_SEL_ONES
        |=> o_sample == `PAT_ONES)
        else $error("Test pattern was altered by formatting.");
endmodule : sample_formatter
`default_nettype wire

/* spi_frame.sv */
// Serial frame engine: bit counting, write capture and readback shifting.
`timescale 1ns/1ps
`default_nettype none
`include "adc_cfg_map.svh"
module spi_frame (
    input wire logic i_clock,
    input wire logic i_arst_n,
    input wire logic i_active,
    input wire logic i_sck_rise,
    input wire logic i_sck_fall,
    input wire logic i_sdi,
    input wire logic [7:0] i_read_data,
    output logic o_write,
    output logic [6:0] o_addr,
    output logic [7:0] o_wdata,
    output logic o_sdo_release
);
    logic [4:0] count_reg, count_next;
    logic [6:0] shift_reg, shift_next, addr_reg, addr_next;
    logic [7:0] wdata_reg, wdata_next, out_reg, out_next;
    logic read_reg, read_next, write_reg, write_next, sdo_reg, sdo_next;
    always_comb begin
        count_next = count_reg;
        shift_next = shift_reg;
        addr_next = addr_reg;
        wdata_next = wdata_reg;
        out_next = out_reg;
        read_next = read_reg;
        write_next = 1'b0;
        sdo_next = sdo_reg;
        if (!i_active) begin
            count_next = 5'h00;
            read_next = 1'b0;
            sdo_next = 1'b1;
        end else begin
            if (i_sck_rise && count_reg != `FRAME_BITS) begin
                shift_next = {shift_reg[5:0], i_sdi};
                count_next = count_reg + 5'h01;
                if (count_reg == `ADDR_LAST) begin
                    addr_next = {shift_reg[5:0], i_sdi};
                    read_next = shift_reg[6];
                end
                if (count_reg == `DATA_LAST && !read_reg) begin
                    write_next = 1'b1;
                    wdata_next = {shift_reg[6:0], i_sdi};
                end
            end
            if (i_sck_fall && read_reg) begin
                if (count_reg == `ADDR_END) begin
                    sdo_next = i_read_data[7];
                    out_next = {i_read_data[6:0], 1'b0};
                end else if (count_reg != `FRAME_BITS) begin
                    sdo_next = out_reg[7];
                    out_next = {out_reg[6:0], 1'b0};
                end
            end
        end
    end
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            count_reg <= 5'h00;
            shift_reg <= 7'h00;
            addr_reg <= 7'h00;
            wdata_reg <= 8'h00;
            out_reg <= 8'h00;
            read_reg <= 1'b0;
            write_reg <= 1'b0;
            sdo_reg <= 1'b1;
        end else begin
            count_reg <= count_next;
            shift_reg <= shift_next;
            addr_reg <= addr_next;
            wdata_reg <= wdata_next;
            out_reg <= out_next;
            read_reg <= read_next;
            write_reg <= write_next;
            sdo_reg <= sdo_next;
        end
    end
    assign o_write = write_reg;
    assign o_addr = addr_reg;
    assign o_wdata = wdata_reg;
    assign o_sdo_release = sdo_reg;
    chk_extra_edges: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        i_active && i_sck_rise && count_reg == `FRAME_BITS
        |=> count_reg == `FRAME_BITS && !o_write)
        else $error("Edge past the sixteenth was not ignored.");
    chk_read_no_write: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        read_reg && i_active |=> !o_write)
        else $error("Readback frame wrote a register.");
    chk_idle_release: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        !i_active |=> o_sdo_release)
        else $error("Serial output driven outside a readback.");
endmodule : spi_frame
`default_nettype wire

/* adc_output_format_and_spi_config.sv */
// Top of the converter's digital side: mode pins, serial registers, power states, outputs.
//
// What this block does
// - Offset binary default, two's complement selectable.
// - Out-of-range clamps to extreme code, flag set.
// - Randomizer XORs LSB into upper bits.
// - Alternate polarity inverts odd data bits.
// - Randomizer and polarity enabled independently.
// - Test patterns drive flag and data bits.
// - Test pattern bypasses all other formatting.
// - Output disable floats data, flag, clock.
// - Sleep from register or serial clock pin.
// - Nap recovery takes at least 100 samples.
// - Interface select high makes pins static.
// - Static pins: stabilizer, sleep, drive current.
// - Interface select low enables serial port.
// - Frame is chip select low; sixteen edges.
// - Write stores byte; read returns, ignores data.
// - Serial output is open drain.
// - Reset bit clears all mode registers.
// - Reset register at address zero, write only.
// - Range flag delayed with its sample.
`timescale 1ns/1ps
`default_nettype none
`include "adc_cfg_map.svh"
module adc_output_format_and_spi_config #(
    parameter int SLEEP_WAKE_CYCLES = (`SLEEP_WAKE_NS + `CLOCK_NS - 1) / `CLOCK_NS
) (
    input wire logic i_clock,
    input wire logic i_arst_n,
    input wire logic i_interface_select,
    input wire logic i_cs_n,
    input wire logic i_sck,
    input wire logic i_sdi,
    input wire logic i_sample_strobe,
    input wire logic [11:0] i_raw_code,
    input wire logic i_over,
    input wire logic i_under,
    output logic o_sdo,
    output logic o_sdo_oe_n,
    output logic [11:0] o_data,
    output logic o_range_flag,
    output logic o_sample_out_clock,
    output logic o_out_oe_n,
    output logic o_duty_stabilizer_on,
    output logic o_out_clock_invert,
    output logic o_sleep,
    output logic o_nap,
    output logic [2:0] o_drive_code,
    output logic o_samples_valid
);
    import adc_cfg_pkg::*;

    // Pin synchronisers; only the second stage is looked at.
    logic [3:0] meta_reg, meta_next, sync_reg, sync_next;
    logic sck_prev_reg, sck_prev_next;
    logic parallel_mode, cs_n_s, sck_s, sdi_s;
    logic serial_active, sck_rise, sck_fall;

    always_comb begin
        meta_next = {i_interface_select, i_cs_n, i_sck, i_sdi};
        sync_next = meta_reg;
        sck_prev_next = sync_reg[1];
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            meta_reg <= 4'h6;
            sync_reg <= 4'h6;
            sck_prev_reg <= 1'b1;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
            sck_prev_reg <= sck_prev_next;
        end
    end

    assign parallel_mode = sync_reg[3];
    assign cs_n_s = sync_reg[2];
    assign sck_s = sync_reg[1];
    assign sdi_s = sync_reg[0];
    assign serial_active = !parallel_mode && !cs_n_s;
    assign sck_rise = sck_s && !sck_prev_reg;
    assign sck_fall = !sck_s && sck_prev_reg;

    // Serial frame engine.
    logic spi_write, spi_release;
    logic [6:0] spi_addr;
    logic [7:0] spi_wdata, read_data;

    spi_frame u_frame (
        .i_clock(i_clock),
        .i_arst_n(i_arst_n),
        .i_active(serial_active),
        .i_sck_rise(sck_rise),
        .i_sck_fall(sck_fall),
        .i_sdi(sdi_s),
        .i_read_data(read_data),
        .o_write(spi_write),
        .o_addr(spi_addr),
        .o_wdata(spi_wdata),
        .o_sdo_release(spi_release)
    );

    // Mode control registers.
    logic [7:0] power_down_reg, power_down_next;
    logic [7:0] clock_reg, clock_next;
    logic [7:0] output_drive_reg, output_drive_next;
    logic [7:0] format_reg, format_next;
    logic soft_reset;

    // The reset bit is never stored, so it clears itself and cannot be read back.
    assign soft_reset = spi_write && spi_addr == `ADDR_RESET && spi_wdata[`RST_BIT];

    always_comb begin
        power_down_next = power_down_reg;
        clock_next = clock_reg;
        output_drive_next = output_drive_reg;
        format_next = format_reg;
        if (soft_reset) begin
            power_down_next = `REG_CLEAR;
            clock_next = `REG_CLEAR;
            output_drive_next = `REG_CLEAR;
            format_next = `REG_CLEAR;
        end else if (spi_write) begin
            case (spi_addr)
                `ADDR_POWER: power_down_next = spi_wdata & `PD_MASK;
                `ADDR_CLOCK: clock_next = spi_wdata & `CLK_MASK;
                `ADDR_DRIVE: output_drive_next = spi_wdata & `DRV_MASK;
                `ADDR_FORMAT: format_next = spi_wdata & `FMT_MASK;
                default: power_down_next = power_down_reg;
            endcase
        end
    end

    always_comb begin
        case (spi_addr)
            `ADDR_POWER: read_data = power_down_reg;
            `ADDR_CLOCK: read_data = clock_reg;
            `ADDR_DRIVE: read_data = output_drive_reg;
            `ADDR_FORMAT: read_data = format_reg;
            default: read_data = `REG_CLEAR;
        endcase
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            power_down_reg <= `REG_CLEAR;
            clock_reg <= `REG_CLEAR;
            output_drive_reg <= `REG_CLEAR;
            format_reg <= `REG_CLEAR;
        end else begin
            power_down_reg <= power_down_next;
            clock_reg <= clock_next;
            output_drive_reg <= output_drive_next;
            format_reg <= format_next;
        end
    end

    // Effective modes: static pins in parallel mode, registers in serial mode.
    logic mode_sleep, mode_nap, mode_dcs, mode_disable, mode_invert;
    logic [2:0] mode_drive;
    fmt_cfg_t fmt_cfg;

    always_comb begin
        if (parallel_mode) begin
            mode_sleep = sck_s;
            mode_nap = 1'b0;
            mode_dcs = cs_n_s;
            mode_drive = sdi_s ? `DRIVE_1P75MA : `DRIVE_3P5MA;
            mode_disable = 1'b0;
            mode_invert = 1'b0;
            fmt_cfg = '0;
        end else begin
            mode_sleep = power_down_reg[`PD_SLEEP_BIT];
            mode_nap = power_down_reg[`PD_NAP_BIT];
            mode_dcs = clock_reg[`CLK_DCS_BIT];
            mode_drive = output_drive_reg[`DRV_CODE_HI:0];
            mode_disable = output_drive_reg[`DRV_DISABLE_BIT];
            mode_invert = clock_reg[`CLK_INV_BIT];
            fmt_cfg.test_pattern_enable = format_reg[`FMT_TEST_BIT];
            fmt_cfg.pattern = format_reg[`FMT_PAT_HI:`FMT_PAT_LO];
            fmt_cfg.abp = format_reg[`FMT_ABP_BIT];
            fmt_cfg.randomize = format_reg[`FMT_RAND_BIT];
            fmt_cfg.twos = format_reg[`FMT_TWOS_BIT];
        end
    end

    // Power states and wake-up accounting.
    power_state_t power_reg, power_next;
    logic [15:0] wake_cnt_reg, wake_cnt_next;
    localparam logic [15:0] SLEEP_WAKE_COUNT = 16'(SLEEP_WAKE_CYCLES);

    always_comb begin
        power_next = power_reg;
        wake_cnt_next = wake_cnt_reg;
        if (mode_sleep) begin
            power_next = PWR_SLEEP;
        end else if (mode_nap) begin
            power_next = PWR_NAP;
        end else begin
            case (power_reg)
                PWR_SLEEP: begin
                    power_next = PWR_WAKE_TIME;
                    wake_cnt_next = SLEEP_WAKE_COUNT;
                end
                PWR_NAP: begin
                    power_next = PWR_WAKE_SAMPLES;
                    wake_cnt_next = `NAP_WAKE_SAMPLES;
                end
                PWR_WAKE_TIME: begin
                    wake_cnt_next = wake_cnt_reg - 16'h0001;
                    if (wake_cnt_reg == 16'h0001) begin
                        power_next = PWR_WAKE_SAMPLES;
                        wake_cnt_next = `SLEEP_WAKE_SAMPLES;
                    end
                end
                PWR_WAKE_SAMPLES: begin
                    if (i_sample_strobe) begin
                        wake_cnt_next = wake_cnt_reg - 16'h0001;
                        if (wake_cnt_reg == 16'h0001) begin
                            power_next = PWR_RUN;
                        end
                    end
                end
                default: power_next = PWR_RUN;
            endcase
        end
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            power_reg <= PWR_RUN;
            wake_cnt_reg <= 16'h0000;
        end else begin
            power_reg <= power_next;
            wake_cnt_reg <= wake_cnt_next;
        end
    end

    // Output formatter.
    logic fmt_strobe;
    sample_t fmt_sample;

    sample_formatter u_format (
        .i_clock(i_clock),
        .i_arst_n(i_arst_n),
        .i_strobe(i_sample_strobe),
        .i_raw_code(i_raw_code),
        .i_over(i_over),
        .i_under(i_under),
        .i_cfg(fmt_cfg),
        .o_strobe(fmt_strobe),
        .o_sample(fmt_sample)
    );

    // Output stage; every pin leaves from a flop.
    sample_t word_reg, word_next;
    logic toggle_reg, toggle_next, out_clk_reg, out_clk_next, oe_n_reg, oe_n_next;
    logic sdo_oe_n_reg, sdo_oe_n_next, dcs_reg, dcs_next, inv_reg, inv_next;
    logic sleep_reg, sleep_next, nap_reg, nap_next, valid_reg, valid_next;
    logic [2:0] drive_reg, drive_next;

    always_comb begin
        word_next = fmt_strobe ? fmt_sample : word_reg;
        toggle_next = fmt_strobe ? ~toggle_reg : toggle_reg;
        out_clk_next = toggle_next ^ mode_invert;
        oe_n_next = mode_disable;
        // The pad pulls low only for zero bits; ones rely on the external pull-up.
        sdo_oe_n_next = spi_release;
        dcs_next = mode_dcs;
        inv_next = mode_invert;
        sleep_next = mode_sleep;
        nap_next = mode_nap && !mode_sleep;
        drive_next = mode_drive;
        valid_next = power_next == PWR_RUN;
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            word_reg <= '0;
            toggle_reg <= 1'b0;
            out_clk_reg <= 1'b0;
            oe_n_reg <= 1'b0;
            sdo_oe_n_reg <= 1'b1;
            dcs_reg <= 1'b0;
            inv_reg <= 1'b0;
            sleep_reg <= 1'b0;
            nap_reg <= 1'b0;
            drive_reg <= `DRIVE_3P5MA;
            valid_reg <= 1'b1;
        end else begin
            word_reg <= word_next;
            toggle_reg <= toggle_next;
            out_clk_reg <= out_clk_next;
            oe_n_reg <= oe_n_next;
            sdo_oe_n_reg <= sdo_oe_n_next;
            dcs_reg <= dcs_next;
            inv_reg <= inv_next;
            sleep_reg <= sleep_next;
            nap_reg <= nap_next;
            drive_reg <= drive_next;
            valid_reg <= valid_next;
        end
    end

    assign o_data = word_reg.data;
    assign o_range_flag = word_reg.range_flag;
    assign o_sample_out_clock = out_clk_reg;
    assign o_out_oe_n = oe_n_reg;
    assign o_sdo = sdo_oe_n_reg;
    assign o_sdo_oe_n = sdo_oe_n_reg;
    assign o_duty_stabilizer_on = dcs_reg;
    assign o_out_clock_invert = inv_reg;
    assign o_sleep = sleep_reg;
    assign o_nap = nap_reg;
    assign o_drive_code = drive_reg;
    assign o_samples_valid = valid_reg;

    sequence nap_exit_s;
        power_reg == PWR_NAP ##1 power_reg == PWR_WAKE_SAMPLES;
    endsequence
    sequence reset_write_s;
        soft_reset && !parallel_mode;
    endsequence

    chk_soft_reset_clear: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        reset_write_s |=> power_down_reg == `REG_CLEAR && format_reg == `REG_CLEAR
        && clock_reg == `REG_CLEAR && output_drive_reg == `REG_CLEAR)
        else $error("Software reset left a mode bit set.");
    chk_nap_wake_count: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        nap_exit_s |-> wake_cnt_reg == `NAP_WAKE_SAMPLES && !o_samples_valid)
        else $error("Nap recovery did not start at one hundred samples.");
    chk_parallel_sleep: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        parallel_mode && sck_s |=> o_sleep ##1 !o_samples_valid)
        else $error("Static sleep pin did not power down.");
    chk_output_float: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        !parallel_mode && output_drive_reg[`DRV_DISABLE_BIT] |=> o_out_oe_n)
        else $error("Outputs driven while disabled.");
    chk_sdo_in_frame: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        !o_sdo_oe_n |-> !o_sdo && $past(serial_active, 2))
        else $error("Serial output pulled low outside a frame.");
endmodule : adc_output_format_and_spi_config
`default_nettype wire

/* cfg_host.sv */
// Host model that drives the serial configuration port and reads back through the pulled-up line.
`timescale 1ns/1ps
`default_nettype none
module cfg_host (
    input wire logic i_clock,
    input wire logic i_line,
    output logic o_cs_n,
    output logic o_sck,
    output logic o_sdi
);
    initial begin
        o_cs_n = 1'b1;
        o_sck = 1'b0;
        o_sdi = 1'b0;
    end
    task automatic hw(input int n);
        repeat (n) @(negedge i_clock);
    endtask : hw
    // The serial clock stands low between frames, and data is flipped so no stale bit lingers.
    task automatic xfer(input logic [15:0] w, output logic [7:0] rd);
        rd = 8'h00;
        o_cs_n = 1'b0;
        hw(4);
        // A seventeenth pulse makes sure that edges past the sixteenth are ignored.
        for (int i = 0; i < 17; i++) begin
            if (i < 16) o_sdi = w[15 - i];
            hw(4);
            o_sck = 1'b1;
            hw(4);
            if (i >= 8 && i < 16) rd = {rd[6:0], i_line};
            o_sck = 1'b0;
        end
        hw(4);
        o_cs_n = 1'b1;
        o_sdi = ~o_sdi;
        hw(4);
    endtask : xfer
    // Static levels for the parallel mode; they have passed the synchronisers on return.
    task automatic pins(input logic c, input logic s, input logic d);
        o_cs_n = c;
        o_sck = s;
        o_sdi = d;
        hw(8);
    endtask : pins
endmodule : cfg_host
`default_nettype wire

/* tb.sv */
// Self-checking bench for the configuration port and the output word formatter.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_fail++; \
    $display("CHECK FAILED at %0t: got %h want %h", $time, a, e); end end
module tb;
    import adc_cfg_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, strobe = 1'b0, ov = 1'b0, un = 1'b0;
    logic [11:0] raw = 12'h000, data;
    logic cs_n, sck, sdi, sdo, sdo_oe_n, rflag, out_oe_n;
    logic [12:0] expq[$], ex;
    logic [2:0] st = 3'h0;
    logic [15:0] seed = 16'h0013;
    logic [7:0] rd;
    logic sel = 1'b0, dcs, slp, nap, vld, oclk, inv, ck = 1'b0;
    logic [2:0] drv;
    int n_fail = 0, n_compared = 0;
    always #10 clk = ~clk;
    adc_output_format_and_spi_config #(.SLEEP_WAKE_CYCLES(20)) adc_output_format_and_spi_config_i (
        .i_clock(clk), .i_arst_n(rst_n), .i_interface_select(sel), .i_cs_n(cs_n), .i_sck(sck),
        .i_sdi(sdi), .i_sample_strobe(strobe), .i_raw_code(raw), .i_over(ov), .i_under(un),
        .o_sdo(sdo), .o_sdo_oe_n(sdo_oe_n), .o_data(data), .o_range_flag(rflag),
        .o_sample_out_clock(oclk), .o_out_oe_n(out_oe_n), .o_duty_stabilizer_on(dcs),
        .o_out_clock_invert(inv), .o_sleep(slp), .o_nap(nap), .o_drive_code(drv),
        .o_samples_valid(vld));
    // The open-drain line is pulled up whenever the pad lets go.
    cfg_host cfg_host_i (.i_clock(clk), .i_line(sdo_oe_n !== 1'b0), .o_cs_n(cs_n), .o_sck(sck),
        .o_sdi(sdi));
    function automatic logic [15:0] nx(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : nx
    function automatic logic [12:0] fmt(input logic [2:0] c, input logic [11:0] r,
            input logic o, input logic u);
        logic [11:0] d;
        d = o ? 12'hFFF : (u ? 12'h000 : r);
        if (c[0]) d[11] = ~d[11];
        if (c[1]) d[11:1] = d[11:1] ^ {11{d[0]}};
        if (c[2]) d = d ^ 12'hAAA;
        return {o | u, d};
    endfunction : fmt
    task automatic smp(input logic [11:0] r, input logic o, input logic u, input logic [12:0] e);
        @(negedge clk);
        strobe = 1'b1;
        raw = r;
        ov = o;
        un = u;
        expq.push_back(e);
        @(negedge clk);
        strobe = 1'b0;
    endtask : smp
    task automatic results;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : results
    always @(posedge clk) st <= {st[1:0], strobe};
    always @(negedge clk) begin
        if (st[2]) begin
            ex = expq.pop_front();
            `CHK({rflag, data}, ex)
            ck = ~ck;
            `CHK(oclk, ck)
        end
    end
    initial begin
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        cfg_host_i.xfer(16'h0080, rd);
        for (int c = 0; c < 8; c++) begin
            cfg_host_i.xfer({8'h04, 5'h00, c[2:0]}, rd);
            smp(12'h800, 1'b0, 1'b0, fmt(c[2:0], 12'h800, 1'b0, 1'b0));
            for (int k = 0; k < 4; k++) begin
                seed = nx(seed);
                smp(seed[11:0], k == 1, k == 2, fmt(c[2:0], seed[11:0], k == 1, k == 2));
            end
        end
        $display("format test done");
        for (int p = 0; p < 4; p++) begin
            // Each pattern takes four words, an even count, so the phase is back at zero and every pattern opens on its first word.
            cfg_host_i.xfer(16'h0400, rd);
            cfg_host_i.xfer({8'h04, 3'b001, p[1:0], 3'b111}, rd);
            for (int k = 0; k < 4; k++) begin
                seed = nx(seed);
                smp(seed[11:0], k == 3, 1'b0, (p == 0) ? 13'h1FFF : (p == 1) ? 13'h0000 :
                    (p == 2) ? (k[0] ? 13'h0000 : 13'h1FFF) : (k[0] ? 13'h0AAA : 13'h1555));
            end
        end
        $display("pattern test done");
        cfg_host_i.xfer(16'h80FF, rd);
        `CHK(rd, 8'h00)
        for (int k = 0; k < 2; k++) begin
            cfg_host_i.xfer(16'h84C0, rd);
            `CHK(rd, 8'h3F)
        end
        $display("readback test done");
        cfg_host_i.xfer(16'h0308, rd);
        `CHK(out_oe_n, 1'b1)
        cfg_host_i.xfer(16'h0300, rd);
        `CHK(out_oe_n, 1'b0)
        $display("disable test done");
        cfg_host_i.xfer(16'h0209, rd);
        `CHK({dcs, inv}, 2'b11)
        cfg_host_i.xfer(16'h0104, rd);
        `CHK({nap, vld}, 2'b10)
        cfg_host_i.xfer(16'h0100, rd);
        `CHK({nap, vld}, 2'b00)
        cfg_host_i.xfer(16'h0108, rd);
        `CHK({slp, vld}, 2'b10)
        cfg_host_i.xfer(16'h0100, rd);
        `CHK({slp, vld}, 2'b00)
        $display("power test done");
        sel = 1'b1;
        cfg_host_i.pins(1'b1, 1'b1, 1'b1);
        `CHK({dcs, slp, drv}, 5'h19)
        cfg_host_i.pins(1'b0, 1'b0, 1'b0);
        `CHK({dcs, slp, drv, vld}, 6'h00)
        $display("parallel test done");
        results();
    end
    initial begin
        #400_000;
        n_fail++;
        results();
    end
endmodule : tb
`default_nettype wire
